// ==== core/fsq_defs.svh ====
// offsets, field positions, codes and reset values of the field status quality encoder
`ifndef FSQ_DEFS_SVH
`define FSQ_DEFS_SVH
// ==========================================================================
// register offsets (byte addresses, one word each)
`define FSQ_OFF_CTRL     9'h000
`define FSQ_OFF_STATUS   9'h004
`define FSQ_OFF_MASK     9'h008
`define FSQ_OFF_CONFIG   9'h00C
`define FSQ_OFF_WIN_REQ  9'h010
`define FSQ_OFF_WIN_VAL  9'h014
`define FSQ_OFF_WIN_QC   9'h018
`define FSQ_OFF_STANDBY  9'h01C
`define FSQ_OFF_REV7     9'h020
`define FSQ_SEL_VAL      2'h2
`define FSQ_SEL_QC       2'h3
// ==========================================================================
// field positions
`define FSQ_CTRL_EN_BIT  0
`define FSQ_EV_UPDATE    0
`define FSQ_EV_COMMERR   1
`define FSQ_EV_MISUSE    2
`define FSQ_EV_FAILOVER  3
// ==========================================================================
// quality codes
`define FSQ_QC_SYS_INIT  8'h00
`define FSQ_QC_MOD_INIT  8'h37
`define FSQ_QC_GOOD      8'h80
`define FSQ_QC_GOOD_LIM  8'h88
`define FSQ_QC_UNCERTAIN 8'h78
`define FSQ_QC_UPD_FAIL  8'h84
`define FSQ_QC_RESTRICT  8'h24
`define FSQ_QC_COMM_ERR  8'h23
`define FSQ_QC_BAD       8'h28
`define FSQ_QC_POOR      8'h68
`define FSQ_QC_MANUAL    8'h78
`define FSQ_QC_VIA_DYN   8'h40
// ==========================================================================
// first and second status byte fields
`define FSQ_S1_COMM_BIT  7
`define FSQ_RC_UPD_FAIL  8'h08
`define FSQ_RC_RESTRICT  8'h10
`define FSQ_S2_UNC_MASK  8'h17
`define FSQ_REV_NEW      8'h07
`define FSQ_LAST_VAR     2'h3
`endif

// ==== core/fsq_pkg.sv ====
// types shared by the field status quality encoder
package fsq_pkg;
  // ========================================================================
  // cyclic read scheduler states
  typedef enum logic [1:0] {
    PS_IDLE = 2'b01,
    PS_WAIT = 2'b10
  } fsq_poll_t;
  typedef logic [7:0] fsq_qc_t;  // one quality code
endpackage

// ==== core/fsq_map_if.sv ====
// carrier between the encoder and its quality mapper
interface fsq_map_if;
  logic             rev7;     // field device revision 7 or later
  logic             viaDyn;   // variables read by the older dynamic command
  logic             commErr;  // communication failure
  logic             absent;   // variable not provided by field device
  logic [7:0]       stat1;    // first status byte (response code)
  logic [7:0]       stat2;    // second status byte (device status)
  logic [7:0]       per_variable_status;      // per_variable_status byte
  fsq_pkg::fsq_qc_t qc;       // resulting quality code
  modport enc (output rev7, viaDyn, commErr, absent, stat1, stat2, per_variable_status, input qc);
  modport map (input rev7, viaDyn, commErr, absent, stat1, stat2, per_variable_status, output qc);
endinterface

// ==== core/fsq_quality_map.sv ====
// combinational mapping of one field response onto a quality code
`include "fsq_defs.svh"
module fsq_quality_map (
  fsq_map_if.map m
);
  // ========================================================================
  // mapping, errors first so a refused or lost frame never reads good
  always_comb begin
    logic [1:0] lim;
    lim = m.per_variable_status[5:4];
    if (m.commErr || m.absent || m.stat1[`FSQ_S1_COMM_BIT]) begin
      m.qc = `FSQ_QC_COMM_ERR;
    end else if (m.stat1 == `FSQ_RC_RESTRICT) begin
      m.qc = `FSQ_QC_RESTRICT;
    end else if (m.stat1 == `FSQ_RC_UPD_FAIL) begin
      m.qc = `FSQ_QC_UPD_FAIL;
    end else if (!m.rev7) begin
      // older devices: second status byte only
      if ((m.stat2 & `FSQ_S2_UNC_MASK) != 8'h00) begin
        m.qc = `FSQ_QC_UNCERTAIN;
      end else begin
        m.qc = `FSQ_QC_GOOD;
      end
    end else if (m.viaDyn) begin
      m.qc = `FSQ_QC_VIA_DYN;
    end else begin
      // newer devices: per_variable_status quality and limits
      case (m.per_variable_status[7:6])
        2'b00:   m.qc = `FSQ_QC_BAD | {6'h00, lim};
        2'b01:   m.qc = `FSQ_QC_POOR | {6'h00, lim};
        2'b10:   m.qc = `FSQ_QC_MANUAL | {6'h00, lim};
        default: begin
          if (m.per_variable_status[3] || lim != 2'b00) begin
            m.qc = `FSQ_QC_GOOD_LIM | {6'h00, lim};
          end else begin
            m.qc = `FSQ_QC_GOOD;
          end
        end
      endcase
    end
  end
endmodule // fsq_quality_map

// ==== core/fsq_encoder.sv ====
// field status quality encoder: per-variable quality table, request window, cyclic reads
// Notes on behaviour
// - older revisions use first and second status bytes
// - code: quality 7..6, sub-status 5..2, limits 1..0
// - older: config/cold start/fixed current stay good
// - older: extra status, saturation, limits give uncertain
// - update failure response gives 0x84
// - access restricted response gives 0x24
// - communication failure or missing variable gives 0x23
// - start-up, window misuse, failover load 0x37
// - 0x00 is the system initialization value
// - failover puts the channel in standby
// - newer revisions use per_variable_status
// - newer good: 0x80, low 0x89, high 0x8A
// - newer bad, poor, manual carry limit bits
// - further status available maps to 0x88..0x8B
// - newer read through dynamic command gives 0x40
// - enabled channels are read cyclically by itself
// - window returns any one configured variable
//
// Added by the designer: the register addresses and the strobed register port.
`include "fsq_defs.svh"
module fsq_encoder #(
  parameter int CHANNELS = 8,  // field channels
  parameter int VARS     = 4   // variables per channel
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [8:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrStb,
  input  wire logic        regRdStb,
  output logic      [31:0] regRdData,
  output logic             irq,
  input  wire logic        rspValid,
  input  wire logic [2:0]  rspChan,
  input  wire logic [1:0]  rspVar,
  input  wire logic [7:0]  rspRev,
  input  wire logic [7:0]  rspStat1,
  input  wire logic [7:0]  rspStat2,
  input  wire logic [7:0]  rspDvs,
  input  wire logic        rspViaDyn,
  input  wire logic        rspCommErr,
  input  wire logic        rspAbsent,
  input  wire logic [31:0] rspValue,
  input  wire logic        failover,
  input  wire logic [2:0]  failChan,
  output logic             pollReq,
  output logic      [2:0]  pollChan,
  output logic             pollNewCmd
);
  localparam int ENTRIES = CHANNELS * VARS;
  // ========================================================================
  // storage and control state
  logic [31:0]      valMem_q [ENTRIES];  // last value of each variable
  fsq_pkg::fsq_qc_t qcMem_q  [ENTRIES];  // quality code of each variable
  logic             enable_q;            // field protocol enabled
  logic [3:0]       status_q;            // sticky events
  logic [3:0]       mask_q;              // interrupt mask
  logic [31:0]      config_q;            // variables configured for the window
  logic [4:0]       winIdx_q;            // entry requested through the window
  logic             winLive_q;           // window follows a valid entry
  logic [31:0]      winVal_q;            // window value
  fsq_pkg::fsq_qc_t winQc_q;             // window quality code
  logic [7:0]       standby_q;           // channels in standby
  logic [7:0]       rev7_q;              // channels reporting revision 7+
  logic [31:0]      rdData_q;
  logic             irq_q;
  fsq_pkg::fsq_poll_t pollSt_q;
  logic             pollReq_q;
  logic [2:0]       pollChan_q;
  logic             pollNew_q;
  // ========================================================================
  // decode and events
  logic [4:0] rspIdx;      // table entry of this response
  logic       accept;      // response taken into the table
  logic       rspRev7;     // this response comes from a newer device
  logic       winWr;       // software window request
  logic       winBad;      // window request for an unconfigured entry
  logic       statusRd;    // status read, clears sticky bits
  logic [3:0] events;      // event pulses this cycle
  fsq_map_if  mapIf ();
  assign rspIdx   = {rspChan, rspVar};
  // standby channels keep their start-up code until software releases them
  assign accept   = rspValid && enable_q && !standby_q[rspChan];
  assign rspRev7  = rspRev >= `FSQ_REV_NEW;
  assign winWr    = regWrStb && regAddr == `FSQ_OFF_WIN_REQ;
  assign winBad   = !config_q[regWrData[4:0]];
  assign statusRd = regRdStb && regAddr == `FSQ_OFF_STATUS;
  assign events[`FSQ_EV_UPDATE]   = accept;
  assign events[`FSQ_EV_COMMERR]  = accept && (rspCommErr || rspAbsent);
  assign events[`FSQ_EV_MISUSE]   = winWr && winBad;
  assign events[`FSQ_EV_FAILOVER] = failover;
  // ========================================================================
  // feed the mapper with the response in flight
  assign mapIf.rev7    = rspRev7;
  assign mapIf.viaDyn  = rspViaDyn;
  assign mapIf.commErr = rspCommErr;
  assign mapIf.absent  = rspAbsent;
  assign mapIf.stat1   = rspStat1;
  assign mapIf.stat2   = rspStat2;
  assign mapIf.per_variable_status     = rspDvs;
  fsq_quality_map u_map (
    .m (mapIf.map)
  );
  // ========================================================================
  // control registers written by software
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      enable_q <= 1'b0;
      mask_q   <= 4'h0;
      config_q <= 32'h0000_0000;
    end else if (regWrStb) begin
      case (regAddr)
        `FSQ_OFF_CTRL:   enable_q <= regWrData[`FSQ_CTRL_EN_BIT];
        `FSQ_OFF_MASK:   mask_q   <= regWrData[3:0];
        `FSQ_OFF_CONFIG: config_q <= regWrData;
        default: ;  // other offsets handled elsewhere or ignored
      endcase
    end
  end
  // ========================================================================
  // sticky status, cleared by reading it; a new event beats the clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status_q <= 4'h0;
    end else if (statusRd) begin
      status_q <= events;
    end else begin
      status_q <= status_q | events;
    end
  end
  // level interrupt from any unmasked sticky bit
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |((statusRd ? events : (status_q | events)) & mask_q);
    end
  end
  // ========================================================================
  // standby and revision per channel
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      standby_q <= 8'h00;
    end else begin
      // writing ones releases channels; a failover in the same cycle wins
      if (regWrStb && regAddr == `FSQ_OFF_STANDBY) begin
        standby_q <= standby_q & ~regWrData[7:0];
      end
      if (failover) begin
        standby_q[failChan] <= 1'b1;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rev7_q <= 8'h00;
    end else if (accept && !rspCommErr) begin
      rev7_q[rspChan] <= rspRev7;
    end
  end
  // ========================================================================
  // variable table; start-up and failover load the module's init code
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < ENTRIES; i++) begin
        qcMem_q[i]  <= `FSQ_QC_MOD_INIT;
        valMem_q[i] <= 32'h0000_0000;
      end
    end else begin
      if (accept) begin
        qcMem_q[rspIdx] <= mapIf.qc;
        if (!rspCommErr && !rspAbsent) begin
          valMem_q[rspIdx] <= rspValue;
        end
      end
      if (failover) begin
        for (int v = 0; v < VARS; v++) begin
          qcMem_q[{failChan, 2'(v)}] <= `FSQ_QC_MOD_INIT;
        end
      end
    end
  end
  // ========================================================================
  // variable request window; a bad request shows the init code
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      winIdx_q  <= 5'h00;
      winLive_q <= 1'b0;
      winVal_q  <= 32'h0000_0000;
      winQc_q   <= `FSQ_QC_SYS_INIT;
    end else if (winWr) begin
      winIdx_q  <= regWrData[4:0];
      winLive_q <= !winBad;
      if (winBad) begin
        winVal_q <= 32'h0000_0000;
        winQc_q  <= `FSQ_QC_MOD_INIT;
      end else begin
        winVal_q <= valMem_q[regWrData[4:0]];
        winQc_q  <= qcMem_q[regWrData[4:0]];
      end
    end else if (winLive_q && accept && rspIdx == winIdx_q) begin
      // keep the window current as the cyclic reads refresh its entry
      winQc_q <= mapIf.qc;
      if (!rspCommErr && !rspAbsent) begin
        winVal_q <= rspValue;
      end
    end else if (winLive_q && failover && winIdx_q[4:2] == failChan) begin
      winQc_q <= `FSQ_QC_MOD_INIT;
    end
  end
  // ========================================================================
  // cyclic read scheduler: one channel at a time, all variables per turn
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pollSt_q   <= fsq_pkg::PS_IDLE;
      pollReq_q  <= 1'b0;
      pollChan_q <= 3'h0;
      pollNew_q  <= 1'b0;
    end else begin
      case (pollSt_q)
        fsq_pkg::PS_IDLE: begin
          if (enable_q) begin
            pollReq_q <= 1'b1;
            pollNew_q <= rev7_q[pollChan_q];
            pollSt_q  <= fsq_pkg::PS_WAIT;
          end
        end
        fsq_pkg::PS_WAIT: begin
          // a lost frame or the last variable ends this channel's turn
          if (!enable_q) begin
            pollReq_q <= 1'b0;
            pollSt_q  <= fsq_pkg::PS_IDLE;
          end else if (rspValid && rspChan == pollChan_q &&
                       (rspCommErr || rspVar == `FSQ_LAST_VAR)) begin
            pollReq_q  <= 1'b0;
            pollChan_q <= pollChan_q + 3'h1;
            pollSt_q   <= fsq_pkg::PS_IDLE;
          end
        end
        default: begin
          pollReq_q <= 1'b0;
          pollSt_q  <= fsq_pkg::PS_IDLE;
        end
      endcase
    end
  end
  // ========================================================================
  // read port: data stand only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdData_q <= 32'h0000_0000;
    end else if (!regRdStb) begin
      rdData_q <= 32'h0000_0000;
    end else if (regAddr[8:7] == `FSQ_SEL_VAL) begin
      rdData_q <= valMem_q[regAddr[6:2]];
    end else if (regAddr[8:7] == `FSQ_SEL_QC) begin
      rdData_q <= {24'h00_0000, qcMem_q[regAddr[6:2]]};
    end else begin
      case (regAddr)
        `FSQ_OFF_CTRL:    rdData_q <= {31'h0000_0000, enable_q};
        `FSQ_OFF_STATUS:  rdData_q <= {28'h000_0000, status_q};
        `FSQ_OFF_MASK:    rdData_q <= {28'h000_0000, mask_q};
        `FSQ_OFF_CONFIG:  rdData_q <= config_q;
        `FSQ_OFF_WIN_REQ: rdData_q <= {26'h000_0000, winLive_q, winIdx_q};
        `FSQ_OFF_WIN_VAL: rdData_q <= winVal_q;
        `FSQ_OFF_WIN_QC:  rdData_q <= {24'h00_0000, winQc_q};
        `FSQ_OFF_STANDBY: rdData_q <= {24'h00_0000, standby_q};
        `FSQ_OFF_REV7:    rdData_q <= {24'h00_0000, rev7_q};
        default:          rdData_q <= 32'h0000_0000;  // unmapped reads zero
      endcase
    end
  end
  assign regRdData  = rdData_q;
  assign irq        = irq_q;
  assign pollReq    = pollReq_q;
  assign pollChan   = pollChan_q;
  assign pollNewCmd = pollNew_q;
  // ========================================================================
  // checks
  logic noErr;  // response carries no error of any kind
  assign noErr = !rspCommErr && !rspAbsent && rspStat1 == 8'h00;
  old_good_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rspValid && !rspRev7 && noErr && (rspStat2 & `FSQ_S2_UNC_MASK) == 8'h00
    |-> mapIf.qc == 8'h80) else $error("older device not reported good");
  old_uncertain_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rspValid && !rspRev7 && noErr && (rspStat2 & `FSQ_S2_UNC_MASK) != 8'h00
    |-> mapIf.qc == 8'h78) else $error("older device not reported uncertain");
  upd_fail_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rspValid && !rspCommErr && !rspAbsent && rspStat1 == 8'h08
    |-> mapIf.qc == 8'h84) else $error("update failure code wrong");
  // a failover in the same cycle overwrites the stored code, so it is left out
  restricted_a: assert property (@(posedge mclk) disable iff (sys_rst)
    accept && !rspCommErr && !rspAbsent && rspStat1 == 8'h10 && !failover
    |=> qcMem_q[$past(rspIdx)] == 8'h24) else $error("restricted code not stored");
  comm_err_a: assert property (@(posedge mclk) disable iff (sys_rst)
    accept && rspCommErr && !failover
    |=> qcMem_q[$past(rspIdx)] == 8'h23 && status_q[`FSQ_EV_COMMERR])
    else $error("communication failure not recorded");
  new_low_limit_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rspValid && rspRev7 && !rspViaDyn && noErr && rspDvs[7:3] == 5'b11010
    |-> mapIf.qc == 8'h89) else $error("good low limit code wrong");
  new_via_dyn_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rspValid && rspRev7 && rspViaDyn && noErr
    |-> mapIf.qc == 8'h40) else $error("dynamic command read code wrong");
  failover_init_a: assert property (@(posedge mclk) disable iff (sys_rst)
    failover |=> standby_q[$past(failChan)] && qcMem_q[{$past(failChan), 2'h0}] == 8'h37
    ##1 standby_q[$past(failChan, 2)] || $past(regWrStb))
    else $error("failover did not place channel in standby");
  win_misuse_a: assert property (@(posedge mclk) disable iff (sys_rst)
    winWr && winBad |=> winQc_q == 8'h37 && !winLive_q && status_q[`FSQ_EV_MISUSE])
    else $error("window misuse not flagged");
  // both ways of ending a turn count: a lost frame or the last variable
  poll_advance_a: assert property (@(posedge mclk) disable iff (sys_rst)
    pollReq_q && enable_q && rspValid && rspChan == pollChan_q &&
    (rspCommErr || rspVar == 2'h3) |=> !pollReq_q ##1 (pollReq_q || !enable_q))
    else $error("scheduler stalled");
  // ========================================================================
  // mapping, storage and window checks
  new_bad_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rspValid && rspRev7 && !rspViaDyn && noErr && rspDvs[7:6] == 2'b00
    |-> mapIf.qc == {6'h0A, rspDvs[5:4]}) else $error("newer bad code wrong");
  new_further_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rspValid && rspRev7 && !rspViaDyn && noErr && rspDvs[7:6] == 2'b11 && rspDvs[3]
    |-> mapIf.qc == {6'h22, rspDvs[5:4]}) else $error("further status code wrong");
  value_store_a: assert property (@(posedge mclk) disable iff (sys_rst)
    accept && !rspCommErr && !rspAbsent
    |=> valMem_q[$past(rspIdx)] == $past(rspValue)) else $error("value not stored");
  win_follow_a: assert property (@(posedge mclk) disable iff (sys_rst)
    winWr && !winBad && !accept && !failover
    |=> winLive_q && winQc_q == qcMem_q[winIdx_q] && winVal_q == valMem_q[winIdx_q])
    else $error("window does not show the requested entry");
  // ========================================================================
  // scenarios worth seeing
  cov_new_dev_c: cover property (@(posedge mclk) disable iff (sys_rst)
    accept && rspRev7 && !rspViaDyn);
  cov_window_c: cover property (@(posedge mclk) disable iff (sys_rst)
    winWr && !winBad ##[1:20] accept && rspIdx == winIdx_q);
  cov_irq_c: cover property (@(posedge mclk) disable iff (sys_rst)
    irq_q ##1 statusRd ##1 !irq_q);
  cov_failover_c: cover property (@(posedge mclk) disable iff (sys_rst)
    failover ##[1:40] regWrStb && regAddr == `FSQ_OFF_STANDBY);
  cov_poll_wrap_c: cover property (@(posedge mclk) disable iff (sys_rst)
    pollReq_q && pollChan_q == 3'h7 ##[1:20] pollReq_q && pollChan_q == 3'h0);
endmodule // fsq_encoder

// ==== dv/fsq_field_dev_model.sv ====
// field device model: answers cyclic reads and sends bench-ordered responses
module fsq_field_dev_model (
  input  wire logic        mclk,
  input  wire logic        pollReq,
  input  wire logic [2:0]  pollChan,
  input  wire logic        pollNewCmd,
  output logic             rspValid,
  output logic      [2:0]  rspChan,
  output logic      [1:0]  rspVar,
  output logic      [7:0]  rspRev,
  output logic      [7:0]  rspStat1,
  output logic      [7:0]  rspStat2,
  output logic      [7:0]  rspDvs,
  output logic             rspViaDyn,
  output logic             rspCommErr,
  output logic             rspAbsent,
  output logic      [31:0] rspValue
);
  timeunit 1ns;
  timeprecision 100ps;
  logic autoAns = 1'b0;  // answer cyclic reads on its own when set
  // ========================================================================
  // idle lines
  initial begin
    rspValid = 1'b0;
    {rspChan, rspVar, rspRev, rspStat1, rspStat2, rspDvs} = '0;
    {rspViaDyn, rspCommErr, rspAbsent, rspValue} = '0;
  end
  // ========================================================================
  // one response frame for one variable, one cycle long
  task automatic respond(input logic [2:0] c, input logic [1:0] v, input logic [7:0] rev, s1,
                         s2, per_variable_status, input logic [7:0] fl, input logic [31:0] val);
    @(posedge mclk);
    rspValid <= 1'b1;
    {rspChan, rspVar, rspRev, rspStat1, rspStat2, rspDvs} <= {c, v, rev, s1, s2, per_variable_status};
    {rspViaDyn, rspCommErr, rspAbsent, rspValue} <= {fl[2:0], val};
    @(posedge mclk);
    rspValid <= 1'b0;
    // released status, per_variable_status and value lines show the inverse of the frame, so a late sample of them cannot pass by luck
    {rspStat1, rspStat2, rspDvs, rspValue} <= ~{s1, s2, per_variable_status, val};
  endtask
  // ========================================================================
  // cyclic read: four variables per turn, revision matching the command asked for
  initial forever begin
    @(posedge mclk);
    #1;
    if (autoAns && pollReq) begin
      for (int v = 0; v < 4; v++) begin
        respond(pollChan, v[1:0], pollNewCmd ? 8'h07 : 8'h05, 8'h00, 8'h00, 8'hC0, 8'h00,
                32'(v));
      end
    end
  end
endmodule  // fsq_field_dev_model

// ==== dv/tb_field_status_quality_encoder.sv ====
// self-checking bench for the field status quality encoder
`include "fsq_defs.svh"
module tb_field_status_quality_encoder;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, sys_rst, regWrStb, regRdStb, irq, rspValid, rspViaDyn, rspCommErr;
  logic        rspAbsent, failover, pollReq, pollNewCmd;
  logic [8:0]  regAddr;
  logic [31:0] regWrData, regRdData, rspValue, rdVal;
  logic [2:0]  rspChan, failChan, pollChan;
  logic [1:0]  rspVar;
  logic [7:0]  rspRev, rspStat1, rspStat2, rspDvs;
  int          errors = 0;
  int          cmp_count = 0;
  // per case {revision, stat1, stat2, dvs, {viaDyn, commErr, absent}, expected code}
  logic [47:0] cases [16] = '{
    48'h0500_6800_0080, 48'h0500_1000_0078, 48'h0500_0100_0078, 48'h0608_0000_0084,
    48'h0510_0000_0024, 48'h0500_0000_0223, 48'h0500_0000_0123, 48'h0700_00C0_0080,
    48'h0700_00D0_0089, 48'h0700_00E0_008A, 48'h0700_0010_0029, 48'h0700_0060_006A,
    48'h0700_00B0_007B, 48'h0700_00C8_0088, 48'h0700_00C0_0440, 48'h0710_00C0_0024};
  // ========================================================================
  // design and field device
  fsq_encoder dut_u (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .irq(irq),
    .rspValid(rspValid), .rspChan(rspChan), .rspVar(rspVar), .rspRev(rspRev),
    .rspStat1(rspStat1), .rspStat2(rspStat2), .rspDvs(rspDvs), .rspViaDyn(rspViaDyn),
    .rspCommErr(rspCommErr), .rspAbsent(rspAbsent), .rspValue(rspValue), .failover(failover),
    .failChan(failChan), .pollReq(pollReq), .pollChan(pollChan), .pollNewCmd(pollNewCmd));
  fsq_field_dev_model dev_u (.mclk(mclk), .pollReq(pollReq), .pollChan(pollChan),
    .pollNewCmd(pollNewCmd), .rspValid(rspValid), .rspChan(rspChan), .rspVar(rspVar),
    .rspRev(rspRev), .rspStat1(rspStat1), .rspStat2(rspStat2), .rspDvs(rspDvs),
    .rspViaDyn(rspViaDyn), .rspCommErr(rspCommErr), .rspAbsent(rspAbsent), .rspValue(rspValue));
  // ========================================================================
  // clock at 25 ns
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ========================================================================
  // register bus and comparison helpers
  task automatic chk(input string nm, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge mclk);
    {regWrStb, regAddr, regWrData} <= {1'b1, a, d};
    @(posedge mclk);
    regWrStb <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe, so it is taken there
  task automatic rdchk(input string nm, input logic [8:0] a, input logic [31:0] exp);
    @(posedge mclk);
    {regRdStb, regAddr} <= {1'b1, a};
    @(posedge mclk);
    regRdStb <= 1'b0;
    #1;
    chk(nm, exp, regRdData);
  endtask
  task automatic wait_poll(input logic [2:0] c);
    for (int n = 0; n < 400 && !(pollReq === 1'b1 && pollChan === c); n++) begin
      @(posedge mclk);
      #1;
    end
    chk("poll request and channel", {28'h0, 1'b1, c}, {28'h0, pollReq, pollChan});
  endtask
  task automatic print_verdict;
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ========================================================================
  // watchdog: the sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    print_verdict();
  end
  // ========================================================================
  // main sequence
  initial begin
    {sys_rst, regWrStb, regRdStb, regAddr, regWrData, failover, failChan} = '0;
    sys_rst = 1'b1;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    rdchk("qc start", 9'h180, 32'h0000_0037);
    rdchk("win qc start", `FSQ_OFF_WIN_QC, 32'h0000_0000);
    wr(`FSQ_OFF_MASK, 32'h0000_0000);
    wr(`FSQ_OFF_CTRL, 32'h0000_0001);
    for (int i = 0; i < 16; i++) begin
      dev_u.respond(3'd1, i[1:0], cases[i][47:40], cases[i][39:32], cases[i][31:24],
                    cases[i][23:16], cases[i][15:8], 32'(i));
      rdchk("qc case", 9'h180 + 9'((4 + i % 4) * 4), {24'h0, cases[i][7:0]});
    end
    chk("irq masked", 32'h0, {31'h0, irq});
    rdchk("status", `FSQ_OFF_STATUS, 32'h0000_0003);
    wr(`FSQ_OFF_MASK, 32'h0000_0001);
    dev_u.respond(3'd1, 2'd0, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 32'h0);
    repeat (3) @(posedge mclk);
    chk("irq set", 32'h1, {31'h0, irq});
    rdchk("status upd", `FSQ_OFF_STATUS, 32'h0000_0001);
    repeat (3) @(posedge mclk);
    chk("irq clear", 32'h0, {31'h0, irq});
    @(posedge mclk);
    {failover, failChan} <= {1'b1, 3'd1};
    @(posedge mclk);
    failover <= 1'b0;
    rdchk("qc failover", 9'h190, 32'h0000_0037);
    rdchk("standby", `FSQ_OFF_STANDBY, 32'h0000_0002);
    dev_u.respond(3'd1, 2'd0, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 32'h0);
    rdchk("qc standby", 9'h190, 32'h0000_0037);
    wr(`FSQ_OFF_STANDBY, 32'h0000_0002);
    dev_u.respond(3'd1, 2'd1, 8'h07, 8'h00, 8'h00, 8'hC0, 8'h00, 32'h1234_5678);
    rdchk("qc released", 9'h194, 32'h0000_0080);
    rdchk("rev7", `FSQ_OFF_REV7, 32'h0000_0002);
    wr(`FSQ_OFF_CONFIG, 32'h0000_0020);
    wr(`FSQ_OFF_WIN_REQ, 32'h0000_0005);
    rdchk("win value", `FSQ_OFF_WIN_VAL, 32'h1234_5678);
    rdchk("win qc", `FSQ_OFF_WIN_QC, 32'h0000_0080);
    rdchk("value entry 5", 9'h114, 32'h1234_5678);
    wr(`FSQ_OFF_WIN_REQ, 32'h0000_0006);
    rdchk("win misuse", `FSQ_OFF_WIN_QC, 32'h0000_0037);
    rdchk("win misuse value", `FSQ_OFF_WIN_VAL, 32'h0000_0000);
    rdchk("win req", `FSQ_OFF_WIN_REQ, 32'h0000_0006);
    rdchk("status events", `FSQ_OFF_STATUS, 32'h0000_000D);
    rdchk("unmapped", 9'h0FC, 32'h0000_0000);
    dev_u.autoAns = 1'b1;
    wait_poll(3'd1);
    chk("new cmd ch1", 32'h1, {31'h0, pollNewCmd});
    wait_poll(3'd2);
    chk("new cmd ch2", 32'h0, {31'h0, pollNewCmd});
    wait_poll(3'd1);
    print_verdict();
  end
endmodule  // tb_field_status_quality_encoder
